/* hdl/eid_detect.sv */
// External request detection for three request inputs with an
// Avalon-MM register slave and one level interrupt output.
// Assumes port B pins synchronous to sys_clk; one clock, async reset.
// Software clears flags by writing ones; the mask gates irq only.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Sense bit 0: low level raises request
// - Sense bit 1: detect on signal edge
// - Edge direction from two-bit edge field
// - Edge field 00 selects falling edge
// - Edge field 01 selects rising edge
// - Pin2 field bits 10-11, pin1 12-13
// - Detected edge sets pin status flag
// - Port B mode 001 routes pin to request
module eid_detect (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [eid_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [eid_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [eid_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] portb_pin_in,
    output logic [2:0] ext_request_q,
    output logic irq
);
    import eid_pkg::*;

    // ------------------------------------------------------------
    // Notes for users
    // ------------------------------------------------------------
    // Pins must already be synchronous to sys_clk; a raw line needs
    // a synchroniser in front, which would add two cycles of delay.
    // A pulse shorter than one clock period may go unseen.
    // Level sense keeps setting its flag while the input stays low,
    // so a clear written then does not stick.
    // Edge field values 10 and 11 watch both edges.
    // Routing a pin that is already low, with falling edges selected,
    // counts as an edge: the parked input was high the cycle before.
    // Mask bits gate the interrupt output only; flags set regardless.
    // The bus answers every access after exactly one wait cycle.

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0] old_v,
        input logic [DATA_W-1:0] wdata,
        input logic [3:0] be
    );
        logic [REG_W-1:0] res;
        res = old_v;
        if (be[0]) begin
            res[LANE_W-1:0] = wdata[LANE_W-1:0];
        end
        if (be[1]) begin
            res[REG_W-1:LANE_W] = wdata[REG_W-1:LANE_W];
        end
        return res;
    endfunction : merge16

    // Edge match for one request input
    function automatic logic edge_hit(
        input logic [1:0] sel,
        input logic prev_v,
        input logic now_v
    );
        logic fall;
        logic rise;
        fall = prev_v & ~now_v;
        rise = ~prev_v & now_v;
        // Codes 10 and 11 are spare; both edges keeps them useful
        case (sel)
            ES_FALL: edge_hit = fall;
            ES_RISE: edge_hit = rise;
            default: edge_hit = fall | rise;
        endcase
    endfunction : edge_hit

    // Port B routing for one pin: only mode 001 hands the pin to the
    // detector, anything else parks the input at its idle high level
    function automatic logic pb_route(
        input logic [2:0] mode_v,
        input logic pin_v
    );
        if (mode_v == PB_MODE_REQ) begin
            pb_route = pin_v;
        end else begin
            pb_route = LINE_IDLE;
        end
    endfunction : pb_route

    // Place the three per-input events at their flag positions
    function automatic logic [REG_W-1:0] flag_vec(
        input logic [2:0] ev
    );
        logic [REG_W-1:0] res;
        res = RST_REG;
        res[POS_PIN0] = ev[0];
        res[POS_PIN1] = ev[1];
        res[POS_PIN2] = ev[2];
        return res;
    endfunction : flag_vec

    // Pick the three per-input bits out of a 16-bit register
    function automatic logic [2:0] pin_bits(
        input logic [REG_W-1:0] reg_v
    );
        pin_bits = {reg_v[POS_PIN2], reg_v[POS_PIN1], reg_v[POS_PIN0]};
    endfunction : pin_bits

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [REG_W-1:0] sense_ctrl_q;
    logic [REG_W-1:0] edge_ctrl_q;
    logic [REG_W-1:0] pb_upper_q;
    logic [REG_W-1:0] pb_lower_q;
    logic [REG_W-1:0] status_q;
    logic [REG_W-1:0] status_d;
    logic [REG_W-1:0] mask_q;
    logic [2:0] req_prev_q;
    logic [DATA_W-1:0] rdata_q;
    logic wait_q;
    logic irq_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Register map, word addressed, 16-bit registers in the low half:
    //   sense control   bits 7,6,5 for inputs 0,1,2; 0 low, 1 edge
    //   status          bits 7,6,5, sticky, write one to clear
    //   edge control    bits 15:14, 13:12, 11:10 for inputs 0,1,2
    //   port B upper    bits 10,11,12: mode bit 2 of pins 2,3,4
    //   port B lower    bits 5:4, 7:6, 9:8: mode bits 1:0 of pins 2,3,4
    //   mask            bits 7,6,5, same layout as status
    // Unmapped words read zero and ignore writes.
    // A write commits on the cycle the master sees waitrequest low
    wire logic bus_req = avs_read | avs_write;
    wire logic commit = avs_write & ~wait_q;
    wire logic sel_sense = avs_address == IDX_SENSE_CTRL;
    wire logic sel_status = avs_address == IDX_STATUS;
    wire logic sel_edge = avs_address == IDX_EDGE_CTRL;
    wire logic sel_pbu = avs_address == IDX_PB_UPPER;
    wire logic sel_pbl = avs_address == IDX_PB_LOWER;
    wire logic sel_mask = avs_address == IDX_IRQ_MASK;

    // One strobe per register keeps each always_ff short
    wire logic wr_sense = commit & sel_sense;
    wire logic wr_status = commit & sel_status;
    wire logic wr_edge = commit & sel_edge;
    wire logic wr_pbu = commit & sel_pbu;
    wire logic wr_pbl = commit & sel_pbl;
    wire logic wr_mask = commit & sel_mask;
    wire logic rd_take = avs_read & wait_q;

    // Read mux; unmapped addresses read as zero
    wire logic [REG_W-1:0] rd_mux =
        sel_sense ? sense_ctrl_q :
        sel_status ? status_q :
        sel_edge ? edge_ctrl_q :
        sel_pbu ? pb_upper_q :
        sel_pbl ? pb_lower_q :
        sel_mask ? mask_q : RST_REG;

    // ------------------------------------------------------------
    // Pin routing and detection
    // ------------------------------------------------------------
    // Port B mode fields, bit 2 in upper, bits 1:0 in lower register
    wire logic [2:0] mode_pb2 = {pb_upper_q[POS_PB2_MD2], pb_lower_q[POS_PB2_MD0 +: 2]};
    wire logic [2:0] mode_pb3 = {pb_upper_q[POS_PB3_MD2], pb_lower_q[POS_PB3_MD0 +: 2]};
    wire logic [2:0] mode_pb4 = {pb_upper_q[POS_PB4_MD2], pb_lower_q[POS_PB4_MD0 +: 2]};

    // Unrouted inputs idle high so they never look low; unrouting a low pin shows one rising edge
    wire logic [2:0] req_in = {
        pb_route(mode_pb4, portb_pin_in[2]),
        pb_route(mode_pb3, portb_pin_in[1]),
        pb_route(mode_pb2, portb_pin_in[0])
    };

    // Sense select per input: 0 low level, 1 edge
    wire logic [2:0] sense_edge = pin_bits(sense_ctrl_q);
    wire logic [1:0] es_pin0 = edge_ctrl_q[POS_ES_PIN0 +: 2];
    wire logic [1:0] es_pin1 = edge_ctrl_q[POS_ES_PIN1 +: 2];
    wire logic [1:0] es_pin2 = edge_ctrl_q[POS_ES_PIN2 +: 2];

    // Edge events, each against its own input's previous value
    wire logic [2:0] edge_ev = {
        edge_hit(es_pin2, req_prev_q[2], req_in[2]),
        edge_hit(es_pin1, req_prev_q[1], req_in[1]),
        edge_hit(es_pin0, req_prev_q[0], req_in[0])
    };

    // Per-input request: level mode while low, else on edge
    wire logic [2:0] req_ev = (~sense_edge & ~req_in)
                            | (sense_edge & edge_ev);

    // Every event, edge or level, lands on its input's flag
    wire logic [REG_W-1:0] set_vec = flag_vec(req_ev);

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Write-one-to-clear; a same-cycle event wins over the clear
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~(merge16(RST_REG, avs_writedata, avs_byteenable)
                                    & MASK_FLAGS);
        end
        status_d = status_d | set_vec;
    end

    // ------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------
    // Sense select bits; a new mode applies from the next edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sense_ctrl_q <= RST_REG;
        end else if (wr_sense) begin
            sense_ctrl_q <= merge16(sense_ctrl_q, avs_writedata, avs_byteenable);
        end
    end

    // Edge direction fields of all three inputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_ctrl_q <= RST_REG;
        end else if (wr_edge) begin
            edge_ctrl_q <= merge16(edge_ctrl_q, avs_writedata, avs_byteenable);
        end
    end

    // Port B mode bit 2 of pins 2, 3 and 4
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_upper_q <= RST_REG;
        end else if (wr_pbu) begin
            pb_upper_q <= merge16(pb_upper_q, avs_writedata, avs_byteenable);
        end
    end

    // Port B mode bits 1:0 of pins 2, 3 and 4
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_lower_q <= RST_REG;
        end else if (wr_pbl) begin
            pb_lower_q <= merge16(pb_lower_q, avs_writedata, avs_byteenable);
        end
    end

    // Mask keeps the flag bits only, so reserved bits read zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_q <= RST_REG;
        end else if (wr_mask) begin
            mask_q <= merge16(mask_q, avs_writedata, avs_byteenable) & MASK_FLAGS;
        end
    end

    // ------------------------------------------------------------
    // Detector state and outputs
    // ------------------------------------------------------------
    // Previous input values; idle high so reset shows no edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_prev_q <= REQ_IDLE;
        end else begin
            req_prev_q <= req_in;
        end
    end

    // Sticky flags, next value from the clear and set logic above
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_q <= RST_REG;
        end else begin
            status_q <= status_d;
        end
    end

    // Requests follow the events one edge later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_request_q <= REQ_NONE;
        end else begin
            ext_request_q <= req_ev;
        end
    end

    // Interrupt from the next status, so it rises with the flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= IRQ_IDLE;
        end else begin
            irq_q <= |(status_d & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle, then a one-cycle answer; the master may hold
    // its next request at once, as the answer edge raises the wait
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_q <= WAIT_IDLE;
        end else begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    // Read data captured when the request is taken and held until
    // the next read, so it stands at the answer edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= RD_ZERO;
        end else if (rd_take) begin
            rdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
        end
    end

    // Outputs straight from flip-flops
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign irq = irq_q;

endmodule : eid_detect

`default_nettype wire

/* hdl/eid_pkg.sv */
// Constants for the external request detector: register indices,
// field positions, reset values and bus widths.
// Assumes a word-addressed Avalon-MM bus with 32-bit data.
package eid_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned NPIN = 3;

    // ------------------------------------------------------------
    // Register indices (word address on the bus)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_SENSE_CTRL = 32'hFFFF_8358;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 32'hFFFF_835A;
    localparam logic [ADDR_W-1:0] IDX_EDGE_CTRL = 32'hFFFF_8366;
    localparam logic [ADDR_W-1:0] IDX_PB_UPPER = 32'hFFFF_8398;
    localparam logic [ADDR_W-1:0] IDX_PB_LOWER = 32'hFFFF_839A;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 32'hFFFF_8370;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Sense select and status flag share positions: pin0..2 -> 7,6,5
    localparam int unsigned POS_PIN0 = 7;
    localparam int unsigned POS_PIN1 = 6;
    localparam int unsigned POS_PIN2 = 5;
    // Edge select fields, two bits each, low bit position
    localparam int unsigned POS_ES_PIN0 = 14;
    localparam int unsigned POS_ES_PIN1 = 12;
    localparam int unsigned POS_ES_PIN2 = 10;
    // Port B mode bit 2 in the upper register
    localparam int unsigned POS_PB2_MD2 = 10;
    localparam int unsigned POS_PB3_MD2 = 11;
    localparam int unsigned POS_PB4_MD2 = 12;
    // Port B mode bits 1:0 in the lower register, low bit position
    localparam int unsigned POS_PB2_MD0 = 4;
    localparam int unsigned POS_PB3_MD0 = 6;
    localparam int unsigned POS_PB4_MD0 = 8;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] ES_FALL = 2'h0;
    localparam logic [1:0] ES_RISE = 2'h1;
    localparam logic [2:0] PB_MODE_REQ = 3'h1;
    localparam logic [REG_W-1:0] RST_REG = 16'h0000;
    localparam logic [REG_W-1:0] MASK_FLAGS = 16'h00E0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
    localparam logic [NPIN-1:0] REQ_IDLE = 3'h7;
    localparam logic [NPIN-1:0] REQ_NONE = 3'h0;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic WAIT_IDLE = 1'b1;
    localparam logic IRQ_IDLE = 1'b0;
    localparam int unsigned LANE_W = 8;

endpackage : eid_pkg

/* test/eid_detect_props.sv */
// Checker for the request detector's bus and request ports.
// Assumes one clock and an async active-high reset; bound to eid_detect.
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Port relations
// ------------------------------
module eid_detect_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [eid_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] portb_pin_in,
    input wire logic [2:0] ext_request_q,
    input wire logic irq
);
    import eid_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Bus steps: request taken, then exactly one answer cycle
    sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_handshake; s_taken |=> s_answer; endproperty
    property p_idle; !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest; endproperty
    property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
    property p_rd_upper; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
    property p_rd_stable; avs_write && avs_waitrequest |=> $stable(avs_readdata); endproperty
    // A request needs a low line or a change one cycle back
    property p_req_cause; (ext_request_q & $past(portb_pin_in)
        & ~($past(portb_pin_in) ^ $past(portb_pin_in, 2))) == 3'h0; endproperty
    property p_irq_rise; $rose(irq) |-> (ext_request_q != 3'h0) || $past(avs_write)
        || $past(avs_write, 2); endproperty
    // Flags stick, so only a write may drop the interrupt
    property p_irq_fall; $fell(irq) |-> $past(avs_write) || $past(avs_write, 2); endproperty
    a_handshake: assert property (p_handshake) else $error("bus answer not one cycle");
    a_idle: assert property (p_idle) else $error("wait dropped without request");
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper half not zero");
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved on write");
    a_req_cause: assert property (p_req_cause) else $error("request without cause");
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
endmodule : eid_detect_props
bind eid_detect eid_detect_props eid_detect_props_i (.sys_clk(sys_clk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .portb_pin_in(portb_pin_in),
    .ext_request_q(ext_request_q), .irq(irq));
`default_nettype wire

/* test/eid_sensor_model.sv */
// Pole-position sensor lines driving the three port B request pins.
// Assumes the bench sets target levels; lines idle high as if pulled up.
`timescale 1ns/10ps
`default_nettype none
module eid_sensor_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] level_cmd,
    output logic [2:0] pin_out
);
    // Registered so lines change just after an edge, never on it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_out <= 3'h7;
        end else begin
            pin_out <= level_cmd;
        end
    end
endmodule : eid_sensor_model
`default_nettype wire

/* test/eid_detect_test.sv */
// Self-checking bench for the external request detector.
// Assumes eid_detect, the checker and the sensor model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module eid_detect_test;
    import eid_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic avs_waitrequest, irq;
    logic [31:0] avs_address = 32'h0000_0000, avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd_v;
    logic [2:0] level_cmd = 3'h7, pin_w, ext_req;
    int fail_count = 0, n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    eid_sensor_model eid_sensor_model_i (.sys_clk(sys_clk), .rst(rst),
        .level_cmd(level_cmd), .pin_out(pin_w));
    eid_detect eid_detect_i (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .portb_pin_in(pin_w),
        .ext_request_q(ext_req), .irq(irq));
    // ------------------------------
    // Bus and compare tasks
    // ------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Request held until waitrequest is seen low; a spare edge avoids re-entry
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd_v = avs_readdata;
        avs_read <= 1'b0;
        check(rd_v, exp);
        @(posedge sys_clk);
    endtask : rd
    task automatic pins(input logic [2:0] v);
        level_cmd <= v;
        repeat (4) @(posedge sys_clk);
    endtask : pins
    task automatic report_and_stop;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog: the run needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        report_and_stop();
    end
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(IDX_SENSE_CTRL, 32'h0000_0000);
        rd(IDX_EDGE_CTRL, 32'h0000_0000);
        rd(32'hFFFF_8300, 32'h0000_0000);
        wr(IDX_PB_LOWER, 32'h0000_0150);
        wr(IDX_IRQ_MASK, 32'h0000_00E0);
        wr(IDX_SENSE_CTRL, 32'h0000_00E0);
        wr(IDX_EDGE_CTRL, 32'h0000_4400);
        rd(IDX_EDGE_CTRL, 32'h0000_4400);
        // Falling on all: only pin1 watches falling, pins 0 and 2 rising
        pins(3'h0);
        rd(IDX_STATUS, 32'h0000_0040);
        check({31'h0, irq}, 32'h1);
        pins(3'h7);
        rd(IDX_STATUS, 32'h0000_00E0);
        wr(IDX_STATUS, 32'h0000_00E0);
        rd(IDX_STATUS, 32'h0000_0000);
        // Pin0 back to level sense
        wr(IDX_SENSE_CTRL, 32'h0000_0060);
        pins(3'h6);
        check({29'h0, ext_req}, 32'h1);
        rd(IDX_STATUS, 32'h0000_0080);
        wr(IDX_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        pins(3'h7);
        wr(IDX_STATUS, 32'h0000_00E0);
        // Unrouted pins must not reach the detector
        wr(IDX_PB_LOWER, 32'h0000_0000);
        pins(3'h6);
        rd(IDX_STATUS, 32'h0000_0000);
        check({29'h0, ext_req}, 32'h0);
        report_and_stop();
    end
endmodule : eid_detect_test
`default_nettype wire
